// [common/topc_pkg.sv]
// Package with register map, field layout, reset values and modes of the timer output block.
package topc_pkg;

	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;

	// Register indices; the byte address is four times the index.
	localparam logic [15:0] IDX_PORT_DIR = 16'hff23;
	localparam logic [15:0] IDX_RUN_MODE = 16'hff86;
	localparam logic [15:0] IDX_PRESCALE = 16'hff87;
	localparam logic [15:0] IDX_OUT_CTRL = 16'hff89;
	localparam logic [15:0] IDX_CMP_A = 16'hff8a;
	localparam logic [15:0] IDX_CMP_B = 16'hff8b;
	localparam logic [15:0] IDX_COUNT = 16'hff8c;

	// Output control fields.
	localparam int OC_SW_TRIG = 6;
	localparam int OC_ONESHOT = 5;
	localparam int OC_INV_B = 4;
	localparam int OC_LVL_HIGH = 3;
	localparam int OC_LVL_LOW = 2;
	localparam int OC_INV_A = 1;
	localparam int OC_OE = 0;

	// Prescaler and edge mode fields.
	localparam int PE_EDGE_B_LSB = 6;
	localparam int PE_EDGE_A_LSB = 4;
	localparam int PE_CLK_LSB = 0;

	// Run mode register fields.
	localparam int RM_RUN_LSB = 2;
	localparam int RM_OUT_COND = 1;
	localparam int RM_OVF = 0;

	// Port direction: bits above the implemented pins read as one.
	localparam int DIR_W = 5;
	localparam int DIR_SHARED = 4;
	localparam int DIR_INPUT_A = 3;
	localparam logic [7:0] PORT_DIR_RST = 8'hff;
	localparam logic [7:0] PRESCALE_RST = 8'h00;
	localparam logic [7:0] OUT_CTRL_RST = 8'h00;
	localparam logic [7:0] RUN_MODE_RST = 8'h00;

	// Prescaler divide masks.
	localparam logic [7:0] DIV4_MASK = 8'h03;
	localparam logic [7:0] DIV256_MASK = 8'hff;

	typedef enum logic [1:0] {
		RUN_STOP = 2'b00,
		RUN_FREE = 2'b01,
		RUN_EDGE_CLR = 2'b10,
		RUN_MATCH_CLR = 2'b11
	} topc_run_e;

	typedef enum logic [1:0] {
		EDGE_FALL = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_BAD = 2'b10,
		EDGE_BOTH = 2'b11
	} topc_edge_e;

	typedef enum logic [1:0] {
		CLK_DIV1 = 2'b00,
		CLK_DIV4 = 2'b01,
		CLK_DIV256 = 2'b10,
		CLK_EDGE_A = 2'b11
	} topc_clk_e;

	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} topc_bus_e;

	function automatic logic topc_hit(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
		return addr == {idx, 2'b00};
	endfunction

endpackage

// [verilog/topc_edge.sv]
// Filtered valid-edge detector for one timer input pin.
`timescale 1ns/1ps
module topc_edge
	import topc_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic pin,
	input wire logic enable,
	input wire logic [1:0] sel,
	output logic edge_pulse
);

	typedef struct packed {
		logic samp;
		logic level;
		logic seen;
		logic pulse;
	} topc_edge_s;

	topc_edge_s st_r;
	topc_edge_s st_nxt;

	always_comb begin
		logic rise;
		logic fall;
		rise = 1'b0;
		fall = 1'b0;
		st_nxt = st_r;
		st_nxt.samp = pin;
		st_nxt.seen = st_r.seen | enable;
		// A new level is taken only after two equal samples; before the first
		// enable the level stays low, so a high pin then counts as rising.
		if ((st_r.seen || enable) && st_r.samp == pin) begin
			st_nxt.level = pin;
		end
		rise = st_nxt.level & ~st_r.level;
		fall = ~st_nxt.level & st_r.level;
		case (topc_edge_e'(sel))
			EDGE_FALL: st_nxt.pulse = enable & fall;
			EDGE_RISE: st_nxt.pulse = enable & rise;
			EDGE_BOTH: st_nxt.pulse = enable & (rise | fall);
			default: st_nxt.pulse = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign edge_pulse = st_r.pulse;

endmodule // topc_edge

// [verilog/topc_ctrl.sv]
// Timer output control, prescaler and port direction block with an Avalon-MM slave.
//
// Behaviour
// - one-shot trigger restarts counter, reads zero.
// - select bit picks successive or one-shot.
// - no one-shot in compare-A clear mode.
// - B match toggles output when enabled.
// - B match event always raised.
// - A match toggles when enabled, event always.
// - level pair forces low, high, or nothing.
// - level bits are triggers reading zero.
// - output held low while disabled.
// - prescaler resets zero, writable while running.
// - input B edge field selects edge.
// - input A edge field selects edge.
// - clock field picks divider or input A.
// - first enable treats high pin as rising.
// - direction bits, zero output, reset all ones.
// - run mode zero stops and clears counter.
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module topc_ctrl
	import topc_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic edge_input_a,
	input wire logic edge_input_b,
	output logic timer_out_pin,
	output logic shared_pin_o,
	output logic shared_pin_oe,
	output logic input_a_pin_oe,
	output logic [7:0] port3_direction,
	output logic match_a_irq,
	output logic match_b_irq,
	output logic edge_b_event,
	output logic timer_running
);

	if (CNT_W < 9 || CNT_W > 16) begin : g_bad_width
		$error("topc_ctrl: CNT_W must lie between 9 and 16");
	end

	typedef struct packed {
		topc_bus_e bus;
		logic [DATA_W-1:0] rdata;
		logic [DIR_W-1:0] dir;
		logic [1:0] run;
		logic out_cond;
		logic ovf;
		logic [1:0] edge_b;
		logic [1:0] edge_a;
		logic [1:0] clk_sel;
		logic oneshot_sel;
		logic inv_b;
		logic inv_a;
		logic oe_bit;
		logic [CNT_W-1:0] cmp_a;
		logic [CNT_W-1:0] cmp_b;
		logic [CNT_W-1:0] count;
		logic [7:0] div;
		logic armed;
		logic tout;
		logic irq_a;
		logic irq_b;
	} topc_state_s;

	localparam logic [CNT_W-1:0] CNT_MAX = '1;

	topc_state_s st_r;
	topc_state_s st_nxt;
	logic edge_a_pulse;
	logic edge_b_pulse;
	logic running;

	assign running = st_r.run != RUN_STOP;

	topc_edge u_edge_a (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.pin(edge_input_a),
		.enable(running),
		.sel(st_r.edge_a),
		.edge_pulse(edge_a_pulse)
	);

	topc_edge u_edge_b (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.pin(edge_input_b),
		.enable(running),
		.sel(st_r.edge_b),
		.edge_pulse(edge_b_pulse)
	);

	always_comb begin
		logic req;
		logic accept;
		logic wr_lo;
		logic wr_hi;
		logic tick;
		logic sw_trig;
		logic match_a;
		logic match_b;
		logic toggle_ok;
		logic toggle;
		logic [7:0] wb;
		logic [DATA_W-1:0] rd;
		req = avs_read | avs_write;
		accept = req & (st_r.bus == BUS_ACK);
		wr_lo = avs_write & accept & avs_byteenable[0];
		wr_hi = avs_write & accept & avs_byteenable[1];
		wb = avs_writedata[7:0];
		tick = 1'b0;
		sw_trig = 1'b0;
		match_a = 1'b0;
		match_b = 1'b0;
		toggle_ok = 1'b0;
		toggle = 1'b0;
		rd = '0;
		st_nxt = st_r;

		// Each access waits one cycle, then completes on the following edge.
		st_nxt.bus = (req && st_r.bus == BUS_IDLE) ? BUS_ACK : BUS_IDLE;

		if (topc_hit(avs_address, IDX_PORT_DIR)) begin
			rd[7:0] = {3'b111, st_r.dir};
		end else if (topc_hit(avs_address, IDX_RUN_MODE)) begin
			rd[RM_RUN_LSB +: 2] = st_r.run;
			rd[RM_OUT_COND] = st_r.out_cond;
			rd[RM_OVF] = st_r.ovf;
		end else if (topc_hit(avs_address, IDX_PRESCALE)) begin
			rd[PE_EDGE_B_LSB +: 2] = st_r.edge_b;
			rd[PE_EDGE_A_LSB +: 2] = st_r.edge_a;
			rd[PE_CLK_LSB +: 2] = st_r.clk_sel;
		end else if (topc_hit(avs_address, IDX_OUT_CTRL)) begin
			// Trigger bits are not stored and read back as zero.
			rd[OC_ONESHOT] = st_r.oneshot_sel;
			rd[OC_INV_B] = st_r.inv_b;
			rd[OC_INV_A] = st_r.inv_a;
			rd[OC_OE] = st_r.oe_bit;
		end else if (topc_hit(avs_address, IDX_CMP_A)) begin
			rd[CNT_W-1:0] = st_r.cmp_a;
		end else if (topc_hit(avs_address, IDX_CMP_B)) begin
			rd[CNT_W-1:0] = st_r.cmp_b;
		end else if (topc_hit(avs_address, IDX_COUNT)) begin
			rd[CNT_W-1:0] = st_r.count;
		end
		if (avs_read && st_r.bus == BUS_IDLE) begin
			st_nxt.rdata = rd;
		end

		if (wr_lo && topc_hit(avs_address, IDX_PORT_DIR)) begin
			st_nxt.dir = wb[DIR_W-1:0];
		end
		if (wr_lo && topc_hit(avs_address, IDX_RUN_MODE)) begin
			st_nxt.run = wb[RM_RUN_LSB +: 2];
			st_nxt.out_cond = wb[RM_OUT_COND];
		end
		if (wr_lo && topc_hit(avs_address, IDX_PRESCALE)) begin
			st_nxt.edge_b = wb[PE_EDGE_B_LSB +: 2];
			st_nxt.edge_a = wb[PE_EDGE_A_LSB +: 2];
			st_nxt.clk_sel = wb[PE_CLK_LSB +: 2];
		end
		if (wr_lo && topc_hit(avs_address, IDX_OUT_CTRL)) begin
			st_nxt.oneshot_sel = wb[OC_ONESHOT];
			st_nxt.inv_b = wb[OC_INV_B];
			st_nxt.inv_a = wb[OC_INV_A];
			st_nxt.oe_bit = wb[OC_OE];
		end
		if (wr_lo && topc_hit(avs_address, IDX_CMP_A)) begin
			st_nxt.cmp_a[7:0] = wb;
		end
		if (wr_hi && topc_hit(avs_address, IDX_CMP_A)) begin
			st_nxt.cmp_a[CNT_W-1:8] = avs_writedata[CNT_W-1:8];
		end
		if (wr_lo && topc_hit(avs_address, IDX_CMP_B)) begin
			st_nxt.cmp_b[7:0] = wb;
		end
		if (wr_hi && topc_hit(avs_address, IDX_CMP_B)) begin
			st_nxt.cmp_b[CNT_W-1:8] = avs_writedata[CNT_W-1:8];
		end
		sw_trig = wr_lo & topc_hit(avs_address, IDX_OUT_CTRL) & wb[OC_SW_TRIG];

		// Count clock selection from the divider, which runs only while the timer runs and is cleared while stopped, or input A.
		case (topc_clk_e'(st_r.clk_sel))
			CLK_DIV1: tick = 1'b1;
			CLK_DIV4: tick = (st_r.div & DIV4_MASK) == DIV4_MASK;
			CLK_DIV256: tick = st_r.div == DIV256_MASK;
			CLK_EDGE_A: tick = edge_a_pulse;
			default: tick = 1'b0;
		endcase
		st_nxt.div = running ? st_r.div + 8'h01 : '0;

		match_a = running & tick & (st_r.count == st_r.cmp_a);
		match_b = running & tick & (st_r.count == st_r.cmp_b);
		st_nxt.irq_a = match_a;
		st_nxt.irq_b = match_b;

		if (!running) begin
			st_nxt.count = '0;
		end else if (sw_trig) begin
			st_nxt.count = '0;
		end else if (st_r.run == RUN_EDGE_CLR && edge_a_pulse) begin
			st_nxt.count = '0;
		end else if (tick) begin
			if (st_r.run == RUN_MATCH_CLR && match_a) begin
				st_nxt.count = '0;
			end else begin
				st_nxt.count = st_r.count + 1'b1;
			end
		end

		// Overflow flag: a wrap in the same cycle as a clear keeps it set.
		if (!running || (wr_lo && topc_hit(avs_address, IDX_RUN_MODE) && !wb[RM_OVF])) begin
			st_nxt.ovf = 1'b0;
		end else if (wr_lo && topc_hit(avs_address, IDX_RUN_MODE) && wb[RM_OVF]) begin
			st_nxt.ovf = 1'b1;
		end
		if (running && tick && st_r.count == CNT_MAX && st_nxt.count == '0) begin
			st_nxt.ovf = 1'b1;
		end

		// One-shot window: opened by the trigger or, in edge-clear mode, an input A edge, closed on B match.
		if (!running) begin
			st_nxt.armed = 1'b0;
		end else if (sw_trig || (st_r.run == RUN_EDGE_CLR && edge_a_pulse)) begin
			st_nxt.armed = st_r.oneshot_sel;
		end else if (match_b) begin
			st_nxt.armed = 1'b0;
		end
		toggle_ok = !st_r.oneshot_sel || (st_r.armed && st_r.run != RUN_MATCH_CLR);
		toggle = toggle_ok & ((st_r.inv_a & match_a) | (st_r.inv_b & match_b));

		// Level triggers act only when the enable was already set before this write.
		if (!st_nxt.oe_bit) begin
			st_nxt.tout = 1'b0;
		end else if (wr_lo && topc_hit(avs_address, IDX_OUT_CTRL) && st_r.oe_bit &&
			(wb[OC_LVL_HIGH] ^ wb[OC_LVL_LOW])) begin
			st_nxt.tout = wb[OC_LVL_HIGH];
		end else if (toggle) begin
			st_nxt.tout = ~st_r.tout;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
			st_r.bus <= BUS_IDLE;
			st_r.dir <= PORT_DIR_RST[DIR_W-1:0];
			st_r.run <= RUN_MODE_RST[RM_RUN_LSB +: 2];
			st_r.edge_b <= PRESCALE_RST[PE_EDGE_B_LSB +: 2];
			st_r.edge_a <= PRESCALE_RST[PE_EDGE_A_LSB +: 2];
			st_r.clk_sel <= PRESCALE_RST[PE_CLK_LSB +: 2];
			st_r.oe_bit <= OUT_CTRL_RST[OC_OE];
		end else begin
			st_r <= st_nxt;
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & (st_r.bus != BUS_ACK);
	assign avs_readdata = st_r.rdata;
	assign timer_out_pin = st_r.tout;
	assign shared_pin_o = st_r.tout;
	assign shared_pin_oe = ~st_r.dir[DIR_SHARED];
	assign input_a_pin_oe = ~st_r.dir[DIR_INPUT_A];
	assign port3_direction = {3'b111, st_r.dir};
	assign match_a_irq = st_r.irq_a;
	assign match_b_irq = st_r.irq_b;
	assign edge_b_event = edge_b_pulse;
	assign timer_running = running;

endmodule // topc_ctrl

// [tb/topc_ctrl_sva.sv]
// Checker of bus timing, pin routing and timer pulses of the output control block.
`timescale 1ns/1ps
module topc_ctrl_sva (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic timer_out_pin,
	input wire logic shared_pin_o,
	input wire logic shared_pin_oe,
	input wire logic input_a_pin_oe,
	input wire logic [7:0] port3_direction,
	input wire logic match_a_irq,
	input wire logic match_b_irq,
	input wire logic edge_b_event,
	input wire logic timer_running
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer not one cycle late");
	shared_oe_a: assert property (shared_pin_oe == !port3_direction[4])
		else $error("shared pin enable wrong");
	in_a_oe_a: assert property (input_a_pin_oe == !port3_direction[3])
		else $error("input a pin enable wrong");
	dir_top_a: assert property (port3_direction[7:5] == 3'b111)
		else $error("direction top bits not one");
	pin_copy_a: assert property (shared_pin_o == timer_out_pin)
		else $error("shared pin differs from timer output");
	a_pulse_a: assert property (match_a_irq |=> !match_a_irq)
		else $error("match a pulse too long");
	toggle_cause_a: assert property ($changed(timer_out_pin) |->
		match_a_irq || match_b_irq || $past(avs_write && !avs_waitrequest))
		else $error("output moved without cause");
	stop_quiet_a: assert property (!timer_running && !$past(timer_running) |->
		!edge_b_event && !match_a_irq && !match_b_irq)
		else $error("event while stopped");
endmodule // topc_ctrl_sva

bind topc_ctrl topc_ctrl_sva i_topc_ctrl_sva (.core_clk, .arst_n, .avs_read, .avs_write,
	.avs_waitrequest, .timer_out_pin, .shared_pin_o, .shared_pin_oe, .input_a_pin_oe,
	.port3_direction, .match_a_irq, .match_b_irq, .edge_b_event, .timer_running);

// [tb/topc_pins.sv]
// Event source that toggles the timer input pins on request.
`timescale 1ns/1ps
module topc_pins (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic fire_a,
	input wire logic fire_b,
	output logic edge_input_a,
	output logic edge_input_b
);
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			edge_input_a <= 1'b0;
			edge_input_b <= 1'b0;
		end else begin
			edge_input_a <= edge_input_a ^ fire_a;
			edge_input_b <= edge_input_b ^ fire_b;
		end
	end
endmodule // topc_pins

// [tb/tb.sv]
// Self-checking bench for the timer output control block.
`timescale 1ns/1ps
module tb;
	import topc_pkg::*;
	logic core_clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic fire_a = 1'b0, fire_b = 1'b0;
	logic [ADDR_W-1:0] avs_address = '0;
	logic [DATA_W-1:0] avs_writedata = '0, avs_readdata;
	logic [3:0] avs_byteenable = 4'hf;
	logic avs_waitrequest, timer_out_pin, shared_pin_o, shared_pin_oe, input_a_pin_oe;
	logic match_a_irq, match_b_irq, edge_b_event, timer_running, edge_input_a, edge_input_b;
	logic last_out = 1'b0;
	logic [7:0] port3_direction;
	logic [DATA_W-1:0] exp_q[$];
	int errors = 0, check_count = 0, cycles = 0, n_a = 0, n_b = 0, n_e = 0, n_t = 0;
	int seed = 32'hb38ad2b7;

	topc_ctrl #(.CNT_W(9)) i_topc_ctrl (.core_clk, .arst_n, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.edge_input_a, .edge_input_b, .timer_out_pin, .shared_pin_o, .shared_pin_oe,
		.input_a_pin_oe, .port3_direction, .match_a_irq, .match_b_irq, .edge_b_event,
		.timer_running);
	topc_pins i_topc_pins (.core_clk, .arst_n, .fire_a, .fire_b, .edge_input_a, .edge_input_b);

	initial begin
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
		check_count++;
		if (seen !== want) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Outputs are sampled mid-cycle, where they have settled since the rising edge.
	always @(negedge core_clk) begin
		cycles++;
		n_a += match_a_irq;
		n_b += match_b_irq;
		n_e += edge_b_event;
		n_t += (timer_out_pin !== last_out);
		last_out = timer_out_pin;
		if (avs_read && !avs_waitrequest) chk(avs_readdata, exp_q.pop_front());
		if (cycles == 20000) begin
			errors++;
			end_sim();
		end
	end

	task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] d);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rd(input logic [15:0] idx, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		bus(1'b0, idx, 8'h00);
	endtask

	initial begin
		logic [7:0] d;
		logic [7:0] lv[7] = '{8'h1b, 8'h13, 8'h1f, 8'h17, 8'h13, 8'h1f, 8'h1b};
		logic ex[7] = '{1, 1, 1, 0, 0, 0, 1};
		logic [7:0] oc[4] = '{8'h03, 8'h11, 8'h01, 8'h13};
		int ea[4] = '{1, 1, 0, 1};
		int eb[4] = '{1, 1, 0, 0};
		int ba, bb, be, bt;
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		rd(IDX_PORT_DIR, 8'hff);
		rd(IDX_PRESCALE, 8'h00);
		rd(IDX_OUT_CTRL, 8'h00);
		rd(16'h0123, 8'h00);
		for (int i = 0; i < 3; i++) begin
			d = $random(seed);
			bus(1, IDX_PRESCALE, d);
			rd(IDX_PRESCALE, d & 8'hf3);
			bus(1, IDX_PORT_DIR, d);
			rd(IDX_PORT_DIR, d | 8'he0);
			chk(shared_pin_oe, !d[4]);
			chk(input_a_pin_oe, !d[3]);
		end
		$display("register test done");
		bus(1, IDX_OUT_CTRL, 8'h12);
		bus(1, IDX_OUT_CTRL, 8'h13);
		foreach (lv[i]) begin
			bus(1, IDX_OUT_CTRL, lv[i]);
			chk(timer_out_pin, ex[i]);
		end
		rd(IDX_OUT_CTRL, 8'h13);
		bus(1, IDX_OUT_CTRL, 8'h73);
		rd(IDX_OUT_CTRL, 8'h33);
		bus(1, IDX_OUT_CTRL, 8'h12);
		chk(timer_out_pin, 1'b0);
		$display("output level test done");
		bus(1, IDX_PORT_DIR, 8'h18);
		bus(1, IDX_CMP_A, 8'd9);
		bus(1, IDX_CMP_B, 8'd50);
		for (int c = 0; c < 4; c++) begin
			bus(1, IDX_PRESCALE, 8'hf0 | c[1:0]);
			bus(1, IDX_OUT_CTRL, oc[c] & 8'h12);
			bus(1, IDX_OUT_CTRL, oc[c]);
			bus(1, IDX_OUT_CTRL, oc[c] | 8'h04);
			{ba, bb, be, bt} = {n_a, n_b, n_e, n_t};
			bus(1, IDX_RUN_MODE, 8'h04);
			for (int i = 0; i < 300; i++) begin
				fire_a <= i < 60 && i % 5 == 0;
				fire_b <= i < 60 && i % 15 == 0;
				@(posedge core_clk);
			end
			bus(1, IDX_RUN_MODE, 8'h00);
			chk(n_a - ba, ea[c]);
			chk(n_b - bb, eb[c]);
			chk(n_e - be, 4);
			chk(n_t - bt, (oc[c][1] & ea[c]) + (oc[c][4] & eb[c]));
			rd(IDX_COUNT, 8'h00);
			$display("timer row %0d done", c);
		end
		end_sim();
	end
endmodule // tb
